// file: design/gpiop_top.sv
// three-port general purpose i/o with apb register access and pin sharing
`default_nettype none
module gpiop_top
    import gpiop_pkg::*;
(
    // clock, reset, clock enable
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         clk_en,
    // apb slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [gpiop_pkg::ADDR_W-1:0] paddr,
    input  wire logic [gpiop_pkg::DATA_W-1:0] pwdata,
    output logic      [gpiop_pkg::DATA_W-1:0] prdata,
    output logic                              pready,
    output logic                              pslverr,
    // port d pins
    input  wire logic [gpiop_pkg::PD_W-1:0]   pd_in,
    output logic      [gpiop_pkg::PD_W-1:0]   pd_out,
    output logic      [gpiop_pkg::PD_W-1:0]   pd_oe_n,
    output logic      [gpiop_pkg::PD_W-1:0]   pd_pullup,
    // port e pins
    input  wire logic [gpiop_pkg::PE_W-1:0]   pe_in,
    output logic      [gpiop_pkg::PE_W-1:0]   pe_out,
    output logic      [gpiop_pkg::PE_W-1:0]   pe_oe_n,
    // port f pins
    input  wire logic [gpiop_pkg::PF_W-1:0]   pf_in,
    output logic      [gpiop_pkg::PF_W-1:0]   pf_out,
    output logic      [gpiop_pkg::PF_W-1:0]   pf_oe_n,
    // serial peripheral on port d 3..0
    input  wire logic [gpiop_pkg::PD_SPI_W-1:0] spi_out,
    input  wire logic [gpiop_pkg::PD_SPI_W-1:0] spi_drive,
    output logic      [gpiop_pkg::PD_SPI_W-1:0] spi_in,
    // async serial module on port e 1..0
    input  wire logic                         serial_txd,
    output logic                              serial_rxd,
    // timer unit four channels 5..2 on port f 7..4
    input  wire logic [gpiop_pkg::TIM_CH-1:0] tim_out,
    input  wire logic [gpiop_pkg::TIM_CH-1:0] tim_drive,
    output logic      [gpiop_pkg::TIM_CH-1:0] tim_in
);
    import gpiop_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////////
    // helpers

    // readback picks latch for outputs and pin level for inputs
    function automatic logic [MUX_W-1:0] rd_mux(input logic [MUX_W-1:0] latch,
                                                input logic [MUX_W-1:0] pin,
                                                input logic [MUX_W-1:0] dir);
        rd_mux = (latch & dir) | (pin & ~dir);
    endfunction

    function automatic logic idx_mapped(input logic [IDX_W-1:0] idx);
        idx_mapped = (idx == IDX_PD_DATA) || (idx == IDX_PE_DATA) || (idx == IDX_PF_DATA)
                  || (idx == IDX_PD_DIR)  || (idx == IDX_PE_DIR)  || (idx == IDX_PF_DIR)
                  || (idx == IDX_PD_PUE)  || (idx == IDX_SHARE);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////
    // state

    logic [PD_W-1:0]    pd_latch_r;
    logic [PE_W-1:0]    pe_latch_r;
    logic [PF_W-1:0]    pf_latch_r;
    logic [PD_W-1:0]    pd_dir_r;
    logic [PE_W-1:0]    pe_dir_r;
    logic [PF_W-1:0]    pf_dir_r;
    logic [PD_W-1:0]    pd_pue_r;
    logic [SHARE_W-1:0] share_r;
    logic [PD_W-1:0]    pd_s1_r;
    logic [PD_W-1:0]    pd_s2_r;
    logic [PE_W-1:0]    pe_s1_r;
    logic [PE_W-1:0]    pe_s2_r;
    logic [PF_W-1:0]    pf_s1_r;
    logic [PF_W-1:0]    pf_s2_r;
    logic               err_r;

    logic [IDX_W-1:0]   idx;
    logic               addr_ok;
    logic               setup;
    logic               wr_acc;
    logic               serial_en;
    logic               spi_en;
    logic [TIM_CH-1:0]  tim_en;
    logic [PD_W-1:0]    pd_drive_nxt;
    logic [PD_W-1:0]    pd_out_nxt;
    logic [PE_W-1:0]    pe_drive_nxt;
    logic [PE_W-1:0]    pe_out_nxt;
    logic [PF_W-1:0]    pf_drive_nxt;
    logic [PF_W-1:0]    pf_out_nxt;
    logic [DATA_W-1:0]  rdata_nxt;

    assign idx       = paddr[ADDR_W-1:BYTE_W];
    assign addr_ok   = (paddr[BYTE_W-1:0] == ALIGNED) && idx_mapped(idx);
    assign setup     = clk_en && psel && !penable;
    assign wr_acc    = clk_en && psel && penable && pwrite && addr_ok;
    assign serial_en = share_r[SH_SERIAL];
    assign spi_en    = share_r[SH_SPI];
    assign tim_en    = share_r[SH_TIM_LSB +: TIM_CH];

    ////////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: first stage feeds only the second

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pd_s1_r <= '0;
            pd_s2_r <= '0;
            pe_s1_r <= '0;
            pe_s2_r <= '0;
            pf_s1_r <= '0;
            pf_s2_r <= '0;
        end
        else if (clk_en)
        begin
            pd_s1_r <= pd_in;
            pd_s2_r <= pd_s1_r;
            pe_s1_r <= pe_in;
            pe_s2_r <= pe_s1_r;
            pf_s1_r <= pf_in;
            pf_s2_r <= pf_s1_r;
        end
    end

    // shared peripherals see the synchronised pin levels
    assign spi_in     = pd_s2_r[PD_SPI_W-1:0];
    assign serial_rxd = pe_s2_r[PE_RX_BIT];
    assign tim_in     = pf_s2_r[PF_TIM_LSB +: TIM_CH];

    ////////////////////////////////////////////////////////////////////////////////////
    // data latches: no reset, contents unknown until written

    always_ff @(posedge pclk)
    begin
        if (wr_acc && idx == IDX_PD_DATA)
            pd_latch_r <= pwdata[PD_W-1:0];
        if (wr_acc && idx == IDX_PE_DATA)
            pe_latch_r <= pwdata[PE_W-1:0];
        if (wr_acc && idx == IDX_PF_DATA)
            pf_latch_r <= pwdata[PF_W-1:0];
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // direction, pullup enable and pin sharing control

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pd_dir_r <= PD_DIR_RST;
            pe_dir_r <= PE_DIR_RST;
            pf_dir_r <= PF_DIR_RST;
            pd_pue_r <= PD_PUE_RST;
            share_r  <= SHARE_RST;
        end
        else if (wr_acc)
        begin
            if (idx == IDX_PD_DIR)
                pd_dir_r <= pwdata[PD_W-1:0];
            if (idx == IDX_PE_DIR)
                pe_dir_r <= pwdata[PE_W-1:0];
            if (idx == IDX_PF_DIR)
                pf_dir_r <= pwdata[PF_W-1:0];
            if (idx == IDX_PD_PUE)
                pd_pue_r <= pwdata[PD_W-1:0];
            if (idx == IDX_SHARE)
                share_r  <= pwdata[SHARE_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // pin drive selection

    always_comb
    begin
        pd_drive_nxt = pd_dir_r;
        pd_out_nxt   = pd_latch_r;
        if (spi_en)
        begin
            pd_drive_nxt[PD_SPI_W-1:0] = spi_drive;
            pd_out_nxt[PD_SPI_W-1:0]   = spi_out;
        end
        pe_drive_nxt = pe_dir_r;
        pe_out_nxt   = pe_latch_r;
        if (serial_en)
        begin
            pe_drive_nxt[PE_TX_BIT] = 1'b1;
            pe_out_nxt[PE_TX_BIT]   = serial_txd;
            pe_drive_nxt[PE_RX_BIT] = 1'b0;
        end
        pf_drive_nxt = pf_dir_r;
        pf_out_nxt   = pf_latch_r;
        for (int i = 0; i < TIM_CH; i++)
        begin
            if (tim_en[i])
            begin
                pf_drive_nxt[PF_TIM_LSB+i] = tim_drive[i];
                pf_out_nxt[PF_TIM_LSB+i]   = tim_out[i];
            end
        end
    end

    // registered pins; an unwritten latch may show unknown data once driven,
    // which is why software loads the latch before turning a pin to output
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pd_out  <= '0;
            pd_oe_n <= '1;
            pe_out  <= '0;
            pe_oe_n <= '1;
            pf_out  <= '0;
            pf_oe_n <= '1;
        end
        else if (clk_en)
        begin
            pd_out  <= pd_out_nxt;
            pd_oe_n <= ~pd_drive_nxt;
            pe_out  <= pe_out_nxt;
            pe_oe_n <= ~pe_drive_nxt;
            pf_out  <= pf_out_nxt;
            pf_oe_n <= ~pf_drive_nxt;
        end
    end

    // pullup follows the direction bit every cycle, never a driven pin
    assign pd_pullup = pd_pue_r & ~pd_dir_r & pd_oe_n;

    ////////////////////////////////////////////////////////////////////////////////////
    // apb read data and error, captured in the setup cycle

    always_comb
    begin
        rdata_nxt = '0;
        if (addr_ok)
        begin
            unique case (idx)
                IDX_PD_DATA: rdata_nxt = DATA_W'(rd_mux(pd_latch_r, pd_s2_r,
                                                        pd_dir_r));
                IDX_PE_DATA: rdata_nxt = DATA_W'(rd_mux(MUX_W'(pe_latch_r),
                                                        MUX_W'(pe_s2_r),
                                                        MUX_W'(pe_dir_r)));
                IDX_PF_DATA: rdata_nxt = DATA_W'(rd_mux(pf_latch_r, pf_s2_r,
                                                        pf_dir_r));
                IDX_PD_DIR:  rdata_nxt = DATA_W'(pd_dir_r);
                IDX_PE_DIR:  rdata_nxt = DATA_W'(pe_dir_r);
                IDX_PF_DIR:  rdata_nxt = DATA_W'(pf_dir_r);
                IDX_PD_PUE:  rdata_nxt = DATA_W'(pd_pue_r);
                IDX_SHARE:   rdata_nxt = DATA_W'(share_r);
                default:     rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= RDATA_RST;
            err_r  <= 1'b0;
        end
        else if (setup)
        begin
            prdata <= pwrite ? RDATA_RST : rdata_nxt;
            err_r  <= !addr_ok;
        end
    end

    // zero wait states keep the slave simple; the error only shows in access
    assign pready  = 1'b1;
    assign pslverr = psel && penable && err_r;

    ////////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_rd_setup(logic [IDX_W-1:0] ix);
        setup && !pwrite && addr_ok && idx == ix;
    endsequence

    a_dir_after_reset: assert property (
        !$past(presetn) |-> pd_dir_r == PD_DIR_RST && pe_dir_r == PE_DIR_RST
                            && pf_dir_r == PF_DIR_RST)
        else $error("direction not cleared by reset");

    a_latch_write: assert property (
        wr_acc && idx == IDX_PD_DATA |=> pd_latch_r == $past(pwdata[PD_W-1:0]))
        else $error("port d latch missed a write");

    a_read_port_d: assert property (
        s_rd_setup(IDX_PD_DATA) |=>
            prdata == DATA_W'(rd_mux($past(pd_latch_r), $past(pd_s2_r), $past(pd_dir_r))))
        else $error("port d readback wrong");

    a_read_port_e: assert property (
        s_rd_setup(IDX_PE_DATA) |=>
            prdata == DATA_W'(rd_mux(MUX_W'($past(pe_latch_r)), MUX_W'($past(pe_s2_r)),
                                     MUX_W'($past(pe_dir_r)))))
        else $error("port e readback wrong");

    a_read_port_f: assert property (
        s_rd_setup(IDX_PF_DATA) |=>
            prdata == DATA_W'(rd_mux($past(pf_latch_r), $past(pf_s2_r), $past(pf_dir_r))))
        else $error("port f readback wrong");

    a_pullup_gate: assert property (
        (pd_pullup & ~pd_pue_r) == '0 && (pd_pullup & (pd_dir_r | ~pd_oe_n)) == '0)
        else $error("pullup active on output pin");

    a_serial_pins: assert property (
        clk_en && serial_en |=> !pe_oe_n[PE_TX_BIT] && pe_oe_n[PE_RX_BIT]
                                && pe_out[PE_TX_BIT] == $past(serial_txd))
        else $error("serial pins not owned by serial module");

    a_gpio_drive: assert property (
        clk_en && !spi_en |=> pd_oe_n == ~$past(pd_dir_r)
            && (pd_out & $past(pd_dir_r)) == ($past(pd_latch_r) & $past(pd_dir_r)))
        else $error("port d pins do not follow direction");

    a_spi_owns: assert property (
        clk_en && spi_en |=> pd_oe_n[PD_SPI_W-1:0] == ~$past(spi_drive))
        else $error("spi pins not owned by spi");

    a_timer_owns: assert property (
        clk_en && tim_en[0] |=> pf_oe_n[PF_TIM_LSB] == !$past(tim_drive[0])
                                && pf_out[PF_TIM_LSB] == $past(tim_out[0]))
        else $error("timer channel pin not owned by timer");

endmodule
`default_nettype wire

// file: include/gpiop_pkg.sv
// constants shared by the three-port general purpose i/o block
`default_nettype none
package gpiop_pkg;
    // port widths and bus widths
    localparam int PD_W     = 8;
    localparam int PE_W     = 6;
    localparam int PF_W     = 8;
    localparam int DATA_W   = 32;
    localparam int ADDR_W   = 16;
    localparam int IDX_W    = 14;
    localparam int BYTE_W   = 2;
    localparam int MUX_W    = 8;
    // register indexes; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_PD_DATA  = 14'h0003;
    localparam logic [IDX_W-1:0] IDX_PE_DATA  = 14'h0008;
    localparam logic [IDX_W-1:0] IDX_PF_DATA  = 14'h0440;
    localparam logic [IDX_W-1:0] IDX_PD_DIR   = 14'h0007;
    localparam logic [IDX_W-1:0] IDX_PE_DIR   = 14'h000C;
    localparam logic [IDX_W-1:0] IDX_PF_DIR   = 14'h0444;
    localparam logic [IDX_W-1:0] IDX_PD_PUE   = 14'h000B;
    localparam logic [IDX_W-1:0] IDX_SHARE    = 14'h0448;
    localparam logic [BYTE_W-1:0] ALIGNED     = 2'h0;
    // pin sharing control register layout
    localparam int SHARE_W      = 6;
    localparam int SH_SERIAL    = 0;
    localparam int SH_SPI       = 1;
    localparam int SH_TIM_LSB   = 2;
    localparam int TIM_CH       = 4;
    // pin positions of the shared functions
    localparam int PD_SPI_W     = 4;
    localparam int PE_TX_BIT    = 0;
    localparam int PE_RX_BIT    = 1;
    localparam int PF_TIM_LSB   = 4;
    // reset values
    localparam logic [PD_W-1:0]    PD_DIR_RST = 8'h00;
    localparam logic [PE_W-1:0]    PE_DIR_RST = 6'h00;
    localparam logic [PF_W-1:0]    PF_DIR_RST = 8'h00;
    localparam logic [PD_W-1:0]    PD_PUE_RST = 8'h00;
    localparam logic [SHARE_W-1:0] SHARE_RST  = 6'h00;
    localparam logic [DATA_W-1:0]  RDATA_RST  = 32'h00000000;
endpackage
`default_nettype wire

// file: dv/gpiop_pins_model.sv
// pad and outside-world model that resolves the three ports' pin levels
`default_nettype none
module gpiop_pins_model
(
    // pad drive from the block
    input  wire logic [gpiop_pkg::PD_W-1:0] pd_out,
    input  wire logic [gpiop_pkg::PD_W-1:0] pd_oe_n,
    input  wire logic [gpiop_pkg::PD_W-1:0] pd_pullup,
    input  wire logic [gpiop_pkg::PE_W-1:0] pe_out,
    input  wire logic [gpiop_pkg::PE_W-1:0] pe_oe_n,
    input  wire logic [gpiop_pkg::PF_W-1:0] pf_out,
    input  wire logic [gpiop_pkg::PF_W-1:0] pf_oe_n,
    // levels forced by the outside world on undriven pins
    input  wire logic [gpiop_pkg::PD_W-1:0] ext_pd,
    input  wire logic [gpiop_pkg::PE_W-1:0] ext_pe,
    input  wire logic [gpiop_pkg::PF_W-1:0] ext_pf,
    // resolved pin levels back into the block
    output logic      [gpiop_pkg::PD_W-1:0] pd_in,
    output logic      [gpiop_pkg::PE_W-1:0] pe_in,
    output logic      [gpiop_pkg::PF_W-1:0] pf_in
);
    import gpiop_pkg::*;
    ////////////////////////////////////////////////////////////////////////////////
    // a driving pad wins; a pullup beats a floating outside line
    assign pd_in = (~pd_oe_n & pd_out) | (pd_oe_n & (pd_pullup | ext_pd));
    assign pe_in = (~pe_oe_n & pe_out) | (pe_oe_n & ext_pe);
    assign pf_in = (~pf_oe_n & pf_out) | (pf_oe_n & ext_pf);
endmodule
`default_nettype wire

// file: dv/test_gpio_ports_def.sv
// self-checking bench for the three-port i/o block
`default_nettype none
module test_gpio_ports_def;
    timeunit 1ns;
    timeprecision 1ns;
    import gpiop_pkg::*;
    logic                pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
    logic                serial_txd, serial_rxd;
    logic [ADDR_W-1:0]   paddr;
    logic [DATA_W-1:0]   pwdata, prdata, r;
    logic [PD_W-1:0]     pd_in, pd_out, pd_oe_n, pd_pullup, ext_pd, pf_in, pf_out, pf_oe_n, ext_pf;
    logic [PE_W-1:0]     pe_in, pe_out, pe_oe_n, ext_pe;
    logic [3:0]          spi_out, spi_drive, spi_in, tim_out, tim_drive, tim_in;
    logic [7:0]          ld, le, lf, dd, de, df, pu, t, dv_d, dv_e, dv_f, o_d, o_e, o_f;
    logic [7:0]          pl, p_d, p_e, p_f;
    logic [SHARE_W-1:0]  sh;
    logic                e;
    logic [15:0]         seed;
    int                  errors, num_checks;
    localparam logic [IDX_W-1:0] RST_IDX [5] = '{IDX_PD_DIR, IDX_PE_DIR, IDX_PF_DIR,
                                                 IDX_PD_PUE, IDX_SHARE};
    ////////////////////////////////////////////////////////////////////////////////
    gpiop_top dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pd_in(pd_in),
        .pd_out(pd_out), .pd_oe_n(pd_oe_n), .pd_pullup(pd_pullup), .pe_in(pe_in),
        .pe_out(pe_out), .pe_oe_n(pe_oe_n), .pf_in(pf_in), .pf_out(pf_out),
        .pf_oe_n(pf_oe_n), .spi_out(spi_out), .spi_drive(spi_drive), .spi_in(spi_in),
        .serial_txd(serial_txd), .serial_rxd(serial_rxd), .tim_out(tim_out),
        .tim_drive(tim_drive), .tim_in(tim_in));
    gpiop_pins_model pins_u (.pd_out(pd_out), .pd_oe_n(pd_oe_n), .pd_pullup(pd_pullup),
        .pe_out(pe_out), .pe_oe_n(pe_oe_n), .pf_out(pf_out), .pf_oe_n(pf_oe_n),
        .ext_pd(ext_pd), .ext_pe(ext_pe), .ext_pf(ext_pf), .pd_in(pd_in),
        .pe_in(pe_in), .pf_in(pf_in));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] rnd();
        for (int k = 0; k < 8; k++)
            seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed[7:0];
    endfunction
    function automatic logic [7:0] lvl(input logic [7:0] drv, out, pull, ext);
        return (drv & out) | (~drv & (pull | ext));
    endfunction
    function automatic logic [7:0] rd_exp(input logic [7:0] lat, dir, pin);
        return (dir & lat) | (~dir & pin);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer; entered just after a rising edge, waits for pready
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // one idle edge so the next call never re-drives psel in this time step
        @(posedge pclk);
    endtask
    task automatic reg_wr(input logic [IDX_W-1:0] i, input logic [7:0] d);
        logic [31:0] x;
        logic        y;
        apb(1'b1, {i, ALIGNED}, 32'(d), x, y);
    endtask
    task automatic reg_rd(input logic [IDX_W-1:0] i, output logic [31:0] d);
        logic y;
        apb(1'b0, {i, ALIGNED}, 32'h0, d, y);
    endtask
    task automatic reset_chk();
        chk(32'({pd_oe_n, pe_oe_n, pf_oe_n}), 32'h003FFFFF);
        foreach (RST_IDX[k])
        begin
            reg_rd(RST_IDX[k], r);
            chk(r, 32'h0);
        end
        $display("reset test done");
    endtask
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // generous limit: the run needs roughly 2000 cycles
    initial
    begin
        #3000000;
        errors++;
        give_verdict();
    end
    initial
    begin
        {presetn, psel, penable, pwrite, serial_txd} = '0;
        {paddr, pwdata, ext_pd, ext_pe, ext_pf} = '0;
        {spi_out, spi_drive, tim_out, tim_drive} = '0;
        clk_en = 1'b1;
        seed = 16'hB2B2;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        reset_chk();
        // unmapped and misaligned accesses are refused and change nothing
        apb(1'b0, 16'h0004, 32'h0, r, e);
        chk({r[30:0], e}, 32'h1);
        apb(1'b1, {IDX_PD_DIR, 2'h1}, 32'h000000FF, r, e);
        chk(32'(e), 32'h1);
        reg_rd(IDX_PD_DIR, r);
        chk(r, 32'h0);
        $display("refusal test done");
        for (int i = 0; i < 40; i++)
        begin
            ld = rnd(); le = rnd(); lf = rnd(); dd = rnd(); de = rnd(); df = rnd();
            pu = rnd(); t = rnd(); sh = t[5:0];
            if (i == 0)
                {dd, de, df, sh} = '0;
            if (i == 1)
                {dd, de, df, sh} = '1;
            ext_pd <= rnd(); ext_pf <= rnd(); t = rnd();
            ext_pe <= t[5:0]; serial_txd <= t[6];
            {spi_out, spi_drive} <= rnd(); {tim_out, tim_drive} <= rnd();
            reg_wr(IDX_PD_DATA, ld);
            reg_wr(IDX_PE_DATA, le);
            reg_wr(IDX_PF_DATA, lf);
            reg_wr(IDX_PD_DIR, dd);
            reg_rd(IDX_PD_DIR, r);
            chk(r, 32'(dd));
            reg_wr(IDX_PE_DIR, de);
            reg_rd(IDX_PE_DIR, r);
            chk(r, 32'(de[5:0]));
            reg_wr(IDX_PF_DIR, df);
            reg_wr(IDX_PD_PUE, pu);
            reg_wr(IDX_SHARE, 8'(sh));
            repeat (4) @(posedge pclk);
            dv_d = sh[SH_SPI] ? {dd[7:4], spi_drive} : dd;
            o_d = sh[SH_SPI] ? {ld[7:4], spi_out} : ld;
            dv_e = sh[SH_SERIAL] ? {2'b0, de[5:2], 2'b01} : {2'b0, de[5:0]};
            o_e = sh[SH_SERIAL] ? {2'b0, le[5:1], serial_txd} : {2'b0, le[5:0]};
            dv_f = {(sh[5:2] & tim_drive) | (~sh[5:2] & df[7:4]), df[3:0]};
            o_f = {(sh[5:2] & tim_out) | (~sh[5:2] & lf[7:4]), lf[3:0]};
            pl = pu & ~dd & ~dv_d;
            p_d = lvl(dv_d, o_d, pl, ext_pd);
            p_e = lvl(dv_e, o_e, 8'h0, {2'b0, ext_pe});
            p_f = lvl(dv_f, o_f, 8'h0, ext_pf);
            reg_rd(IDX_PD_DATA, r);
            chk(r, 32'(rd_exp(ld, dd, p_d)));
            reg_rd(IDX_PE_DATA, r);
            chk(r, 32'(rd_exp({2'b0, le[5:0]}, {2'b0, de[5:0]}, p_e)));
            reg_rd(IDX_PF_DATA, r);
            chk(r, 32'(rd_exp(lf, df, p_f)));
            chk({24'h0, ~pd_oe_n}, 32'(dv_d));
            chk(32'(pd_out & dv_d), 32'(o_d & dv_d));
            chk(32'(pd_pullup), 32'(pl));
            chk({26'h0, ~pe_oe_n}, 32'(dv_e[5:0]));
            chk(32'(pe_out & dv_e[5:0]), 32'(o_e[5:0] & dv_e[5:0]));
            chk({8'h0, ~pf_oe_n, 8'h0, pf_out & dv_f}, {16'(dv_f), 16'(o_f & dv_f)});
            chk(32'({serial_rxd, spi_in, tim_in}), 32'({p_e[1], p_d[3:0], p_f[7:4]}));
        end
        $display("random pin test done");
        // a second reset clears directions but keeps the latches
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        reset_chk();
        reg_wr(IDX_PD_DIR, 8'hFF);
        reg_rd(IDX_PD_DATA, r);
        chk(r, 32'(ld));
        $display("latch retention test done");
        // with the clock enable low a write is lost and the pins hold
        clk_en <= 1'b0;
        reg_wr(IDX_PD_DIR, 8'h00);
        chk({24'h0, ~pd_oe_n}, 32'h000000FF);
        clk_en <= 1'b1;
        reg_rd(IDX_PD_DIR, r);
        chk(r, 32'h000000FF);
        $display("clock enable test done");
        give_verdict();
    end
endmodule
`default_nettype wire
